// File: hw/ctz_regs.vh
`ifndef CTZ_REGS_VH
`define CTZ_REGS_VH

// instruction word fields, bit 0 is the most significant bit of the word
`define CTZ_PRIMARY_OP 6'h1F
`define CTZ_XO_TOUCH_ST 10'h0F6
`define CTZ_XO_ZERO 10'h3F6
`define CTZ_XO_LINE_ST 10'h276

// touch hint encodings
`define CTZ_HINT_SINGLE 4'h0
`define CTZ_HINT_FWD 4'h1
`define CTZ_HINT_BACK 4'h3
`define CTZ_HINT_DESC 4'h8
`define CTZ_HINT_CTRL 4'hA

// stop codes of the stream control word
`define CTZ_STOP_NONE 2'h0
`define CTZ_STOP_ONE 2'h2
`define CTZ_STOP_ALL 2'h3

// cache command codes
`define CTZ_CMD_FETCH_ST 2'h0
`define CTZ_CMD_ZERO_HIT 2'h1
`define CTZ_CMD_ZERO_ALLOC 2'h2
`define CTZ_CMD_WRITEBACK 2'h3

// register byte offsets
`define CTZ_REG_CTRL 12'h000
`define CTZ_REG_STATUS 12'h004
`define CTZ_REG_STREAM_SEL 12'h008
`define CTZ_REG_STREAM_ADDR_LO 12'h00C
`define CTZ_REG_STREAM_ADDR_HI 12'h010
`define CTZ_REG_STREAM_ATTR 12'h014

// control register fields and reset value
`define CTZ_CTRL_HINT_EN 0
`define CTZ_CTRL_STREAM_EN 1
`define CTZ_CTRL_RESET 2'h3

// stream table geometry
`define CTZ_DESC_W 59
`define CTZ_CTRL_W 12
`define CTZ_STREAMS 16

`endif

// File: hw/ctz_stream_mem.v
`timescale 1ns/1ps
`include "ctz_regs.vh"

module ctz_stream_mem (
   // clock
   input wire clk,
   // write side, two independent field groups
   input wire descWe,
   input wire ctrlWe,
   input wire [3:0] wrId,
   input wire [`CTZ_DESC_W-1:0] descIn,
   input wire [`CTZ_CTRL_W-1:0] ctrlIn,
   // read side, data comes from a register
   input wire [3:0] rdId,
   output reg [`CTZ_DESC_W+`CTZ_CTRL_W-1:0] rdData
);

   reg [`CTZ_DESC_W-1:0] descArr [0:`CTZ_STREAMS-1];
   reg [`CTZ_CTRL_W-1:0] ctrlArr [0:`CTZ_STREAMS-1];

   // field writes and registered read
   always @(posedge clk)
   begin
      if (descWe)
      begin
         descArr[wrId] <= descIn;
      end
      if (ctrlWe)
      begin
         ctrlArr[wrId] <= ctrlIn;
      end
      rdData <= {descArr[rdId], ctrlArr[rdId]};
   end

endmodule // ctz_stream_mem

// File: hw/ctz_unit.v
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ctz_regs.vh"

// Behaviour
// [RULE_01] touch address is first source (zero if field 0) plus second
// [RULE_02] touch-for-store prefetches the block and never raises an error
// [RULE_03] touch-for-store in a direct-store segment does nothing
// [RULE_04] touch-for-store checked as load; denied access means silent no-op
// [RULE_05] touch leaves condition field 0 and exception register alone
// [RULE_06] hint ignored for caching-inhibited or guarded locations
// [RULE_07] two-operand form uses hint value zero
// [RULE_08] hint 0000: store expected soon to the single addressed block
// [RULE_09] hint 0001: unlimited store stream at increasing block steps
// [RULE_10] hint 0011: unlimited store stream at decreasing block steps
// [RULE_11] hint 1000: address is a stream descriptor, may announce a store
// [RULE_12] hint 1010: address is a control word: attributes, go or stop
// [RULE_13] descriptor: start in upper 57 bits, direction, unlimited, id
// [RULE_14] control word: go, stop code, unit count, transient, unlimited, id
// [RULE_15] zeroing address is sum when first field nonzero, else second alone
// [RULE_16] block-zero clears a present block or allocates without a read
// [RULE_17] line-zero writes the address back to a nonzero first register
// [RULE_18] zeroing operations are protection-checked as stores
// [RULE_19] block-zero with word bit 31 set is invalid; exception reg kept
// [RULE_20] line-store writes a modified line holding the byte to memory
// [RULE_21] opcode 31 with 246, 1014, 630 selects touch, zero, line-store
module ctz_unit (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // issue side
   input wire opValid,
   input wire [31:0] instrWord,
   input wire twoOperandForm,
   input wire lineOpMode,
   input wire [63:0] firstSourceVal,
   input wire [63:0] secondSourceVal,
   // translation and tag lookup results for the issued address
   input wire directStore,
   input wire loadDenied,
   input wire storeDenied,
   input wire cacheInhibited,
   input wire guardedPage,
   input wire blockPresent,
   input wire lineModified,
   // cache command
   output reg cacheCmdValid,
   output reg [1:0] cacheCmd,
   output reg [63:0] cacheAddr,
   // stream engine events
   output reg streamStart,
   output reg streamBackward,
   output reg [3:0] streamId,
   output reg streamGo,
   output reg streamStop,
   output reg streamStopAll,
   // register write-back and completion
   output reg wbValid,
   output reg [4:0] wbReg,
   output reg [63:0] wbData,
   output reg opDone,
   output reg invalidForm,
   output reg storeFault,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr
);

   reg [1:0] ctrlReg;
   reg [3:0] streamSel;
   reg [15:0] opCount;
   wire [`CTZ_STREAMS-1:0] streamValid;
   wire [`CTZ_DESC_W+`CTZ_CTRL_W-1:0] tableData;
   reg [31:0] next_prdata;
   reg next_pslverr;

   // instruction field extraction
   wire [5:0] primaryOp = instrWord[31:26];
   wire [9:0] extendedOp = instrWord[10:1];
   wire [4:0] firstSourceReg = instrWord[20:16];
   wire formBit = instrWord[0];

   // opcode decode
   wire isMajor = opValid && (primaryOp == `CTZ_PRIMARY_OP); // see [RULE_21]
   wire isTouch = isMajor && (extendedOp == `CTZ_XO_TOUCH_ST); // see [RULE_21]
   wire isZero = isMajor && (extendedOp == `CTZ_XO_ZERO); // see [RULE_21]
   wire isLineSt = isMajor && (extendedOp == `CTZ_XO_LINE_ST); // see [RULE_21]

   // hint field, forced to zero in the short form
   wire [3:0] touchHintField = twoOperandForm ? 4'h0 : // see [RULE_07]
      instrWord[24:21];

   // shared address adder, zero replaces a first field of 0
   wire [63:0] baseVal = (firstSourceReg == 5'h00) ? 64'h0 :
      firstSourceVal; // see [RULE_01] see [RULE_15]
   wire [63:0] effectiveAddr = baseVal + secondSourceVal;

   // stream descriptor fields
   wire [56:0] descStart = effectiveAddr[63:7]; // see [RULE_13]
   wire descDir = effectiveAddr[6]; // see [RULE_13]
   wire unlimitedGoFlag = effectiveAddr[5]; // see [RULE_13]
   wire [3:0] wordId = effectiveAddr[3:0]; // see [RULE_13] see [RULE_14]

   // stream control word fields
   wire ctrlGo = effectiveAddr[31]; // see [RULE_14]
   wire [1:0] ctrlStop = effectiveAddr[30:29]; // see [RULE_14]
   wire [9:0] streamUnitCount = effectiveAddr[16:7]; // see [RULE_14]
   wire ctrlTransient = effectiveAddr[6]; // see [RULE_14]
   wire ctrlUnlimited = effectiveAddr[5]; // see [RULE_14]

   // the touch acts only on cacheable, reachable, enabled targets
   wire touchActive = isTouch && ctrlReg[`CTZ_CTRL_HINT_EN] &&
      !directStore && // see [RULE_03]
      !loadDenied && // see [RULE_04]
      !cacheInhibited && !guardedPage; // see [RULE_06]
   wire streamActive = touchActive && ctrlReg[`CTZ_CTRL_STREAM_EN];

   // stream table writes
   wire descWe = streamActive &&
      (touchHintField == `CTZ_HINT_DESC); // see [RULE_11]
   wire ctrlWordHit = streamActive && (touchHintField == `CTZ_HINT_CTRL);
   wire ctrlWe = ctrlWordHit && (ctrlStop == `CTZ_STOP_NONE); // see [RULE_12]
   wire stopOne = ctrlWordHit && (ctrlStop == `CTZ_STOP_ONE);
   wire stopAll = ctrlWordHit && (ctrlStop == `CTZ_STOP_ALL);

   // zeroing checks
   wire zeroBad = isZero && formBit; // see [RULE_19]
   wire zeroDenied = isZero && !formBit && storeDenied; // see [RULE_18]
   wire zeroGo = isZero && !formBit && !storeDenied;

   // descriptor and control storage
   ctz_stream_mem streamTable (
      .clk(ref_clk),
      .descWe(descWe),
      .ctrlWe(ctrlWe),
      .wrId(wordId),
      .descIn({descStart, descDir, unlimitedGoFlag}),
      .ctrlIn({streamUnitCount, ctrlTransient, ctrlUnlimited}),
      .rdId(streamSel),
      .rdData(tableData)
   );

   // per-stream described flag, set by descriptor, cleared by stop
   genvar gi;
   generate
      for (gi = 0; gi < `CTZ_STREAMS; gi = gi + 1)
      begin : gValid
         reg described;
         always @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               described <= 1'b0;
            end
            else if (descWe && (wordId == gi))
            begin
               described <= 1'b1; // set wins over a stop
            end
            else if (stopAll || (stopOne && (wordId == gi))) // see [RULE_12]
            begin
               described <= 1'b0;
            end
         end
         assign streamValid[gi] = described;
      end
   endgenerate

   // operation stage: one cycle from issue to outputs
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cacheCmdValid <= 1'b0;
         cacheCmd <= `CTZ_CMD_FETCH_ST;
         cacheAddr <= 64'h0;
         streamStart <= 1'b0;
         streamBackward <= 1'b0;
         streamId <= 4'h0;
         streamGo <= 1'b0;
         streamStop <= 1'b0;
         streamStopAll <= 1'b0;
         wbValid <= 1'b0;
         wbReg <= 5'h00;
         wbData <= 64'h0;
         opDone <= 1'b0;
         invalidForm <= 1'b0;
         storeFault <= 1'b0;
         opCount <= 16'h0000;
      end
      else
      begin
         // pulses default low; no condition or exception register port
         cacheCmdValid <= 1'b0; // see [RULE_05] see [RULE_19]
         streamStart <= 1'b0;
         streamGo <= 1'b0;
         streamStop <= 1'b0;
         streamStopAll <= 1'b0;
         wbValid <= 1'b0;
         invalidForm <= zeroBad;
         storeFault <= zeroDenied;
         opDone <= isTouch || isZero || isLineSt; // see [RULE_02]
         if (isTouch || isZero || isLineSt)
         begin
            opCount <= opCount + 16'h0001;
         end
         cacheAddr <= effectiveAddr;
         streamId <= wordId;
         if (touchActive)
         begin
            case (touchHintField)
               `CTZ_HINT_SINGLE:
               begin
                  cacheCmdValid <= 1'b1; // see [RULE_08] see [RULE_02]
                  cacheCmd <= `CTZ_CMD_FETCH_ST;
               end
               `CTZ_HINT_FWD:
               begin
                  cacheCmdValid <= 1'b1;
                  cacheCmd <= `CTZ_CMD_FETCH_ST;
                  streamStart <= ctrlReg[`CTZ_CTRL_STREAM_EN]; // see [RULE_09]
                  streamBackward <= 1'b0;
               end
               `CTZ_HINT_BACK:
               begin
                  cacheCmdValid <= 1'b1;
                  cacheCmd <= `CTZ_CMD_FETCH_ST;
                  streamStart <= ctrlReg[`CTZ_CTRL_STREAM_EN]; // see [RULE_10]
                  streamBackward <= 1'b1;
               end
               `CTZ_HINT_DESC:
               begin
                  // unlimited flag also announces the store, see [RULE_11]
                  streamStart <= streamActive && unlimitedGoFlag;
                  streamBackward <= descDir;
               end
               `CTZ_HINT_CTRL:
               begin
                  streamGo <= ctrlWe && ctrlGo; // see [RULE_12]
                  streamStop <= stopOne || stopAll;
                  streamStopAll <= stopAll;
               end
               default:
               begin
                  cacheCmdValid <= 1'b0;
               end
            endcase
         end
         else if (zeroGo)
         begin
            // clear in place or allocate without a storage read
            cacheCmdValid <= 1'b1;
            cacheCmd <= blockPresent ? `CTZ_CMD_ZERO_HIT :
               `CTZ_CMD_ZERO_ALLOC; // see [RULE_16]
            wbValid <= lineOpMode && (firstSourceReg != 5'h00); // see [RULE_17]
            wbReg <= firstSourceReg;
            wbData <= effectiveAddr;
         end
         else if (isLineSt && blockPresent && lineModified)
         begin
            cacheCmdValid <= 1'b1; // see [RULE_20]
            cacheCmd <= `CTZ_CMD_WRITEBACK;
         end
      end
   end

   // apb read mux for the access phase
   always @*
   begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (paddr == `CTZ_REG_CTRL)
      begin
         next_prdata = {30'h0, ctrlReg};
      end
      else if (paddr == `CTZ_REG_STATUS)
      begin
         next_prdata = {opCount, streamValid};
      end
      else if (paddr == `CTZ_REG_STREAM_SEL)
      begin
         next_prdata = {28'h0, streamSel};
      end
      else if (paddr == `CTZ_REG_STREAM_ADDR_LO)
      begin
         next_prdata = {tableData[38:14], 7'h00};
      end
      else if (paddr == `CTZ_REG_STREAM_ADDR_HI)
      begin
         next_prdata = tableData[70:39];
      end
      else if (paddr == `CTZ_REG_STREAM_ATTR)
      begin
         next_prdata = {18'h0, tableData[11:0], tableData[13:12]};
      end
      else
      begin
         next_pslverr = 1'b1;
      end
   end

   // apb handshake: one wait state, write lands on the completing edge
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         ctrlReg <= `CTZ_CTRL_RESET;
         streamSel <= 4'h0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready)
         begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
         end
         else
         begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
         if (psel && penable && pready && pwrite && !pslverr)
         begin
            if (paddr == `CTZ_REG_CTRL)
            begin
               ctrlReg <= pwdata[1:0];
            end
            else if (paddr == `CTZ_REG_STREAM_SEL)
            begin
               streamSel <= pwdata[3:0];
            end
         end
      end
   end

endmodule // ctz_unit

// File: verification/ctz_issue_model.sv
`timescale 1ns/1ps

module ctz_issue_model (
   // clock
   input wire ref_clk,
   // issue slot toward the unit
   output logic opValid = 1'h0,
   output logic [31:0] instrWord = 32'h0,
   output logic twoOperandForm = 1'h0,
   output logic lineOpMode = 1'h0,
   output logic [63:0] firstSourceVal = 64'h0,
   output logic [63:0] secondSourceVal = 64'h0,
   // {direct, loadDeny, storeDeny, inhibit, guard, present, modified}
   output logic [6:0] attr = 7'h0
);
   // one instruction per call, driven after one edge and held until the next issue or idle call
   task issue(input [31:0] iw, input two, lm, input [63:0] a, b,
      input [6:0] at);
      @(posedge ref_clk);
      opValid <= 1'h1;
      instrWord <= iw;
      twoOperandForm <= two;
      lineOpMode <= lm;
      firstSourceVal <= a;
      secondSourceVal <= b;
      attr <= at;
   endtask
   // a released slot drops opValid and inverts instrWord, secondSourceVal and attr; the other outputs keep their values
   task idle;
      @(posedge ref_clk);
      opValid <= 1'h0;
      instrWord <= ~instrWord;
      secondSourceVal <= ~secondSourceVal;
      attr <= ~attr;
   endtask
endmodule // ctz_issue_model

// File: verification/ctz_unit_sva.sv
`timescale 1ns/1ps
`include "ctz_regs.vh"

module ctz_unit_sva (
   // clock and reset
   input logic ref_clk,
   input logic rst_n,
   // issue side
   input logic opValid,
   input logic [31:0] instrWord,
   input logic twoOperandForm,
   input logic lineOpMode,
   input logic [63:0] firstSourceVal,
   input logic [63:0] secondSourceVal,
   input logic directStore,
   input logic loadDenied,
   input logic storeDenied,
   input logic cacheInhibited,
   input logic guardedPage,
   input logic blockPresent,
   input logic lineModified,
   // results
   input logic cacheCmdValid,
   input logic [1:0] cacheCmd,
   input logic [63:0] cacheAddr,
   input logic streamStart,
   input logic streamBackward,
   input logic [3:0] streamId,
   input logic streamGo,
   input logic wbValid,
   input logic [4:0] wbReg,
   input logic [63:0] wbData,
   input logic opDone,
   input logic invalidForm,
   input logic storeFault
);
   // decode of the issue slot
   wire isOp = opValid && instrWord[31:26] == `CTZ_PRIMARY_OP;
   wire touch = isOp && instrWord[10:1] == `CTZ_XO_TOUCH_ST;
   wire zero = isOp && instrWord[10:1] == `CTZ_XO_ZERO;
   wire lineSt = isOp && instrWord[10:1] == `CTZ_XO_LINE_ST;
   wire zOk = zero && !instrWord[0] && !storeDenied;
   wire [4:0] ra = instrWord[20:16];
   wire [63:0] eaNow = (ra == 5'h0 ? 64'h0 : firstSourceVal) + secondSourceVal;
   wire blocked = directStore || loadDenied || cacheInhibited || guardedPage;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_taken; touch || zero || lineSt |=> opDone; endproperty
   a_taken: assert property (p_taken)
      else $error("op not done");
   property p_ignored; !(touch || zero || lineSt) |=> !opDone; endproperty
   a_ignored: assert property (p_ignored)
      else $error("stray done");
   property p_quiet;
      touch |=> !invalidForm && !storeFault && !wbValid;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("touch fault");
   property p_blocked;
      touch && blocked |=> !cacheCmdValid && !streamStart && !streamGo;
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("touch acted");
   property p_zaddr;
      zOk |=> cacheCmdValid && cacheAddr == $past(eaNow)
         && cacheCmd == ($past(blockPresent) ? 2'h1 : 2'h2);
   endproperty
   a_zaddr: assert property (p_zaddr)
      else $error("zero cmd");
   property p_zwb;
      zOk && lineOpMode && ra != 5'h0 |=> wbValid && wbReg == $past(ra)
         && wbData == $past(eaNow);
   endproperty
   a_zwb: assert property (p_zwb)
      else $error("zero writeback");
   property p_zbad;
      zero && instrWord[0] |=> invalidForm && !cacheCmdValid;
   endproperty
   a_zbad: assert property (p_zbad)
      else $error("bad form");
   property p_zdeny;
      zero && !instrWord[0] && storeDenied |=> storeFault && !cacheCmdValid;
   endproperty
   a_zdeny: assert property (p_zdeny)
      else $error("zero denied");
   property p_line;
      lineSt && blockPresent && lineModified |=> cacheCmdValid
         && cacheCmd == 2'h3;
   endproperty
   a_line: assert property (p_line)
      else $error("line store");
   // stream id follows the issued address one cycle later
   property p_sid; opValid |=> streamId == $past(eaNow[3:0]); endproperty
   a_sid: assert property (p_sid)
      else $error("stream id");
   // a fetched stream hint sets the direction from its encoding
   property p_sdir;
      touch && !twoOperandForm && (instrWord[24:21] == `CTZ_HINT_FWD
         || instrWord[24:21] == `CTZ_HINT_BACK) ##1 cacheCmdValid
         |-> streamBackward == $past(instrWord[22]);
   endproperty
   a_sdir: assert property (p_sdir)
      else $error("stream direction");
endmodule // ctz_unit_sva

bind ctz_unit ctz_unit_sva u_ctz_unit_sva (.ref_clk(ref_clk), .rst_n(rst_n),
   .opValid(opValid), .instrWord(instrWord), .twoOperandForm(twoOperandForm),
   .lineOpMode(lineOpMode), .firstSourceVal(firstSourceVal),
   .secondSourceVal(secondSourceVal), .directStore(directStore),
   .loadDenied(loadDenied), .storeDenied(storeDenied),
   .cacheInhibited(cacheInhibited), .guardedPage(guardedPage),
   .blockPresent(blockPresent), .lineModified(lineModified),
   .cacheCmdValid(cacheCmdValid), .cacheCmd(cacheCmd), .cacheAddr(cacheAddr),
   .streamStart(streamStart), .streamBackward(streamBackward),
   .streamId(streamId), .streamGo(streamGo), .wbValid(wbValid),
   .wbReg(wbReg), .wbData(wbData), .opDone(opDone),
   .invalidForm(invalidForm), .storeFault(storeFault));

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "ctz_regs.vh"

module tb_top;
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic opValid, twoOperandForm, lineOpMode;
   logic [31:0] instrWord, prdata;
   logic [63:0] firstSourceVal, secondSourceVal, cacheAddr;
   logic [6:0] attr;
   logic cacheCmdValid, streamStart, streamGo, streamStop, streamStopAll;
   logic wbValid, opDone, invalidForm, storeFault, pready, pslverr;
   logic [1:0] cacheCmd;
   logic [4:0] wbReg;
   int n_fail = 0;
   int checked = 0;
   logic [1:0] ctl = 2'h3;
   logic [78:0] q[$], dq[$], e, m;
   logic [9:0] xos[4] = '{`CTZ_XO_TOUCH_ST, `CTZ_XO_ZERO, `CTZ_XO_LINE_ST,
      10'h116};
   logic [3:0] hts[6] = '{4'h0, 4'h1, 4'h3, 4'h8, 4'hA, 4'h5};
   wire [78:0] seen = {cacheCmdValid, cacheCmd, cacheAddr, wbValid, wbReg,
      invalidForm, storeFault, streamStart, streamGo, streamStop, streamStopAll};

   // clock
   always #4 ref_clk = ~ref_clk;

   ctz_issue_model u_ctz_issue_model (.ref_clk(ref_clk), .opValid(opValid),
      .instrWord(instrWord), .twoOperandForm(twoOperandForm),
      .lineOpMode(lineOpMode), .firstSourceVal(firstSourceVal),
      .secondSourceVal(secondSourceVal), .attr(attr));

   ctz_unit u_ctz_unit (.ref_clk(ref_clk), .rst_n(rst_n), .opValid(opValid),
      .instrWord(instrWord), .twoOperandForm(twoOperandForm),
      .lineOpMode(lineOpMode), .firstSourceVal(firstSourceVal),
      .secondSourceVal(secondSourceVal), .directStore(attr[6]),
      .loadDenied(attr[5]), .storeDenied(attr[4]), .cacheInhibited(attr[3]),
      .guardedPage(attr[2]), .blockPresent(attr[1]), .lineModified(attr[0]),
      .cacheCmdValid(cacheCmdValid), .cacheCmd(cacheCmd),
      .cacheAddr(cacheAddr), .streamStart(streamStart), .streamBackward(),
      .streamId(), .streamGo(streamGo), .streamStop(streamStop),
      .streamStopAll(streamStopAll), .wbValid(wbValid), .wbReg(wbReg),
      .wbData(), .opDone(opDone), .invalidForm(invalidForm),
      .storeFault(storeFault), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   task chk(input string nm, input logic [78:0] s, x);
      checked++;
      if (s !== x)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, x, s);
      end
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // apb transfer: setup, access, wait for pready
   task apb(input w, input [11:0] a, input [31:0] wd, er, input es);
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'h1;
      do
      begin
         @(posedge ref_clk);
      end
      while (pready !== 1'h1);
      if (!w) chk("prdata", 79'(prdata), 79'(er));
      chk("pslverr", 79'(pslverr), 79'(es));
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // note the expected result, then issue
   task automatic op(input [31:0] iw, input two, lm, input [63:0] a, b,
      input [6:0] at);
      logic [63:0] ea;
      logic [3:0] th;
      logic ok, dn;
      logic [4:0] ra;
      logic [78:0] x, k;
      ra = iw[20:16];
      ea = (ra == 5'h0 ? 64'h0 : a) + b;
      th = two ? 4'h0 : iw[24:21];
      ok = !at[6] && !at[5]
         && !at[3] && !at[2] && ctl[0];
      x = {3'h0, ea, 12'h0};
      k = 79'h0;
      dn = iw[31:26] == `CTZ_PRIMARY_OP;
      case (iw[10:1])
         `CTZ_XO_TOUCH_ST:
         begin
            x[78] = ok && (th == `CTZ_HINT_SINGLE || th == `CTZ_HINT_FWD
               || th == `CTZ_HINT_BACK);
            x[3] = ok && ctl[1] && (th == `CTZ_HINT_FWD || th == `CTZ_HINT_BACK
               || th == `CTZ_HINT_DESC && ea[5]);
            if (ok && ctl[1] && th == `CTZ_HINT_CTRL)
               x[2:0] = {ea[31] && ea[30:29] == 2'h0, ea[30],
                  &ea[30:29]};
         end
         `CTZ_XO_ZERO:
            if (iw[0])
               x[5] = 1'h1;
            else if (at[4])
               x[4] = 1'h1;
            else
               x[78:6] = {at[1] ? 3'h5 : 3'h6, ea, lm && ra != 5'h0,
                  ra};
         `CTZ_XO_LINE_ST:
            x[78:76] = {at[1] && at[0], 2'h3};
         default: dn = 1'h0;
      endcase
      if (!x[78]) k[77:76] = 2'h3;
      if (!x[11]) k[10:6] = 5'h1F;
      if (dn)
      begin
         q.push_back(x);
         dq.push_back(k);
      end
      u_ctz_issue_model.issue(iw, two, lm, a, b, at);
   endtask

   // each completion against the oldest note
   always @(negedge ref_clk)
   begin
      if (opDone === 1'h1)
      begin
         m = dq.pop_front();
         e = q.pop_front();
         chk("op result", seen | m, e | m);
      end
   end

   // main sequence
   initial
   begin
      void'($urandom(32'h890D2B97));
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'h1;
      apb(1'h0, `CTZ_REG_CTRL, 32'h0, {30'h0, `CTZ_CTRL_RESET}, 1'h0);
      apb(1'h1, 12'h018, 32'h5, 32'h0, 1'h1);
      $display("register test done");
      op({`CTZ_PRIMARY_OP, 1'h0, `CTZ_HINT_DESC, 10'h0, `CTZ_XO_TOUCH_ST, 1'h0},
         1'h0, 1'h0, 64'h0, 64'hABCD_0000_1234_5625, 7'h0);
      u_ctz_issue_model.idle();
      apb(1'h1, `CTZ_REG_STREAM_SEL, 32'h5, 32'h0, 1'h0);
      apb(1'h0, `CTZ_REG_STREAM_ADDR_LO, 32'h0, 32'h1234_5600,
         1'h0);
      apb(1'h0, `CTZ_REG_STREAM_ADDR_HI, 32'h0, 32'hABCD_0000,
         1'h0);
      apb(1'h0, `CTZ_REG_STATUS, 32'h0, 32'h0001_0020, 1'h0);
      op({`CTZ_PRIMARY_OP, 1'h0, `CTZ_HINT_CTRL, 10'h0, `CTZ_XO_TOUCH_ST, 1'h0},
         1'h0, 1'h0, 64'h0, 64'h4000_0005, 7'h0);
      u_ctz_issue_model.idle();
      apb(1'h0, `CTZ_REG_STATUS, 32'h0, 32'h0002_0000, 1'h0);
      op({`CTZ_PRIMARY_OP, 1'h0, `CTZ_HINT_CTRL, 10'h0, `CTZ_XO_TOUCH_ST, 1'h0},
         1'h0, 1'h0, 64'h0, 64'h8000_2A65, 7'h0);
      u_ctz_issue_model.idle();
      apb(1'h0, `CTZ_REG_STREAM_ATTR, 32'h0, 32'h0000_054D,
         1'h0);
      $display("stream table test done");
      for (int c = 0; c < 4; c++)
      begin
         apb(1'h1, `CTZ_REG_CTRL, 32'(c), 32'h0, 1'h0);
         ctl = 2'(c);
         repeat (50)
            op({`CTZ_PRIMARY_OP, 1'h0, hts[$urandom % 6], 5'($urandom % 4),
               5'($urandom), xos[$urandom % 4], 1'($urandom % 8 == 0)},
               1'($urandom % 4 == 0), 1'($urandom), {$urandom, $urandom},
               {$urandom, $urandom},
               ($urandom % 3 != 0) ? {5'h0, 2'($urandom)} : 7'($urandom));
         u_ctz_issue_model.idle();
         $display("random batch %0d done", c);
      end
      repeat (3) @(posedge ref_clk);
      chk("pending results", 79'(q.size()), 79'h0);
      end_sim();
   end

   // watchdog
   initial
   begin
      #100000;
      n_fail++;
      end_sim();
   end
endmodule // tb_top
